// >>> cslp_pkg.sv
/*
  Shared constants for the CAN mode, interrupt grouping and reset control block.
  Assumes a 32-bit APB register bus and a protocol core on the same clock.
*/
// What this block does
// - Writing 1 to the sleep request bit sends the controller to sleep.
// - Sleep entry waits for an idle bus when a request meets traffic.
// - After sleep, bus access resumes only after 11 recessive bits.
// - Software writing 0 to the sleep request bit ends sleep.
// - With bus wake selected, bus activity ends sleep automatically.
// - The first frame after a bus wake is discarded, later frames stored.
// - Bus activity in sleep sets bus activity flag; masked flags raise nothing but the reset event.
// - Writing 1 to the halt request bit halts, deferred until bus idle.
// - Halt keeps registers unchanged but for software writes and hardware flag and count events.
// - Clearing the halt request bit ends halt.
// - Every source but the reset event is maskable by the interrupt mask; the mailbox mask covers only data, remote, empty.
// - Error line groups passive, bus-off, and two warning flags; no transfer start.
// - Overrun line groups reset, overload, overwrite, bus activity, timer flags.
// - Mailbox 0 receive may start transfer controller; its end clears flags silently.
// - Reset and standby initialise all registers but not mailbox contents.
// - The reset event flag is set after reset and software standby recovery.
// - Reset status flag reads 1 while asleep.
// - Per-mailbox mask stops empty, remote and data flags for that mailbox.
// - In bus-off, 11 recessive bits bump receive count; 96 and 128 set flags.
// - Register writes take halfword strobes only; longword write strobes are refused, reads are not.
// - A late cancel lets the frame go, sets both acknowledges, clears pending.
package cslp_pkg;
  localparam logic [7:0]  MCR_OFS   = 8'h00;
  localparam logic [7:0]  GSR_OFS   = 8'h04;
  localparam logic [7:0]  IFR_OFS   = 8'h08;
  localparam logic [7:0]  IMR_OFS   = 8'h0C;
  localparam logic [7:0]  MBIM_OFS  = 8'h10;
  localparam logic [7:0]  RXD_OFS   = 8'h14;
  localparam logic [7:0]  RRQ_OFS   = 8'h18;
  localparam logic [7:0]  TRANSMIT_PENDING_REGISTER_OFS  = 8'h1C;
  localparam logic [7:0]  TRANSMIT_CANCEL_REGISTER_OFS  = 8'h20;
  localparam logic [7:0]  ABAK_OFS  = 8'h24;
  localparam logic [7:0]  TXAK_OFS  = 8'h28;
  localparam logic [7:0]  ERRC_OFS  = 8'h2C;
  // Master control fields
  localparam int MCR_HALT = 1;
  localparam int MCR_SLEEP = 5;
  localparam int MCR_WAKE = 7;
  localparam int MCR_XFER = 8;
  // Status fields
  localparam int GSR_WARN = 1;
  localparam int GSR_RST = 3;
  localparam int GSR_DISC = 4;
  localparam int GSR_BOFF = 5;
  // Interrupt flag positions
  localparam int F_RST = 0;
  localparam int F_DATA = 1;
  localparam int F_RMT = 2;
  localparam int F_TXW = 3;
  localparam int F_RXW = 4;
  localparam int F_PASS = 5;
  localparam int F_BOFF = 6;
  localparam int F_OVLD = 7;
  localparam int F_EMPTY = 8;
  localparam int F_OVWR = 9;
  localparam int F_ACT = 12;
  localparam int F_TOVF = 13;
  localparam int F_CMP0 = 14;
  localparam int F_CMP1 = 15;
  // Reset values
  localparam logic [15:0] MCR_RST = 16'h0000;
  localparam logic [15:0] IFR_RST = 16'h0001;
  localparam logic [15:0] IMR_RST = 16'hFFFF;
  localparam logic [31:0] MBIM_RST = 32'hFFFF_FFFF;
  // Counts
  localparam logic [3:0] RECESSIVE_RUN = 4'hB;
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] BUSOFF_LIMIT = 9'h100;
  typedef enum logic [3:0] {
    ST_RUN    = 4'b0001,
    ST_HALT   = 4'b0010,
    ST_SLEEP  = 4'b0100,
    ST_RESYNC = 4'b1000
  } cslp_state_t;
endpackage

// >>> cslp_sync.sv
/*
  Two flip-flop synchroniser for one pin level.
  Assumes the pin is asynchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module cslp_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic d,
  output var  logic q
);
  logic meta_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // cslp_sync
`default_nettype wire

// >>> cslp_flags.sv
/*
  Bank of sticky flags: hardware set wins over any clear in the same cycle.
  Assumes load is a synchronous re-initialisation request.
*/
`timescale 1ns/100ps
`default_nettype none
module cslp_flags #(
  parameter int W = 32,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output var  logic [W-1:0] q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST_VAL;
    end else if (ce) begin
      q <= load ? RST_VAL : ((q & ~clr) | set);
    end
  end
endmodule // cslp_flags
`default_nettype wire

// >>> cslp_ctrl.sv
/*
  Mode control (run, halt, sleep, resync), interrupt flag grouping, error
  counting in bus-off and APB register file of a CAN controller.
  Assumes a protocol core on pclk supplying bit ticks, idle and frame events.
*/
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cslp_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        can_rx,
  input  wire logic        bit_tick,
  input  wire logic        bus_idle,
  input  wire logic        rx_done,
  input  wire logic [4:0]  rx_mbox,
  input  wire logic        rx_remote,
  input  wire logic        tx_done,
  input  wire logic [4:0]  tx_mbox,
  input  wire logic        cancel_done,
  input  wire logic [4:0]  cancel_mbox,
  input  wire logic        overload_sent,
  input  wire logic        overwrite_evt,
  input  wire logic        timer_ovf,
  input  wire logic        cmp0_match,
  input  wire logic        cmp1_match,
  input  wire logic [8:0]  tec_in,
  input  wire logic        rec_up,
  input  wire logic        rec_down,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic        xfer_done,
  output var  logic        xfer_start,
  output var  logic        bus_enable,
  output var  logic        store_enable,
  output var  logic        low_power,
  output var  logic [31:0] tx_pending,
  output var  logic [31:0] tx_cancel,
  output var  logic        error_request_line,
  output var  logic        overrun_request_line,
  output var  logic        receive_request_line,
  output var  logic        empty_request_line
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  cslp_pkg::cslp_state_t state_reg, state_next;
  logic [15:0] mcr_reg, imr_reg, ifr_q, ifr_set, ifr_clr;
  logic [31:0] mbim_reg, transmit_pending_register_reg, transmit_cancel_register_reg, prdata_reg;
  logic [31:0] rxd_q, rrq_q, abak_q, txak_q;
  logic [31:0] rxd_set, rrq_set, abak_set, txak_set, rxd_clr, rrq_clr, abak_clr, txak_clr;
  logic [8:0]  rec_reg;
  logic [3:0]  rcnt_reg;
  logic        discard_reg, xfer_start_reg, sw_stby_q, rx_s;
  logic        twarn_q, rwarn_q, pass_q, boff_q;
  wire         init = hw_standby | sw_standby;
  wire  [31:0] rx_oh = 32'h0000_0001 << rx_mbox;
  wire  [31:0] tx_oh = 32'h0000_0001 << tx_mbox;
  wire  [31:0] cn_oh = 32'h0000_0001 << cancel_mbox;
  wire         in_run = (state_reg == cslp_pkg::ST_RUN);
  wire         in_halt = (state_reg == cslp_pkg::ST_HALT);
  wire         in_sleep = (state_reg == cslp_pkg::ST_SLEEP);
  wire         in_resync = (state_reg == cslp_pkg::ST_RESYNC);
  wire         halt_bit = mcr_reg[cslp_pkg::MCR_HALT];
  wire         sleep_bit = mcr_reg[cslp_pkg::MCR_SLEEP];
  wire         bus_act = in_sleep & ~rx_s;
  wire         wake_evt = bus_act & mcr_reg[cslp_pkg::MCR_WAKE];
  wire         bus_off = (tec_in >= cslp_pkg::BUSOFF_LIMIT);
  wire         run11 = bit_tick & rx_s & (rcnt_reg == cslp_pkg::RECESSIVE_RUN - 4'h1);
  wire         twarn = (tec_in >= cslp_pkg::WARN_LIMIT);
  wire         rwarn = (rec_reg >= cslp_pkg::WARN_LIMIT);
  wire         pass = (tec_in >= cslp_pkg::PASSIVE_LIMIT) | (rec_reg >= cslp_pkg::PASSIVE_LIMIT);
  wire         rx_take = rx_done & ~discard_reg;
  wire         rx_dtc = rx_take & rx_oh[0] & mcr_reg[cslp_pkg::MCR_XFER];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; halfword write lanes only, longword and byte write strobes refused, reads take any strobe
  wire         acc = psel & penable & ce;
  wire         strb_ok = (pstrb == 4'b0011) | (pstrb == 4'b1100) | ~pwrite;
  wire         known = (paddr[1:0] == 2'b00) & (paddr <= cslp_pkg::ERRC_OFS);
  wire         wr = acc & pwrite & strb_ok & known;
  wire  [31:0] lane = {{16{pstrb[3]}}, {16{pstrb[0]}}};
  wire  [31:0] wdat = pwdata & lane;
  wire         w_mcr = wr & (paddr == cslp_pkg::MCR_OFS);
  wire         w_ifr = wr & (paddr == cslp_pkg::IFR_OFS);
  wire         w_imr = wr & (paddr == cslp_pkg::IMR_OFS);
  wire         w_mbim = wr & (paddr == cslp_pkg::MBIM_OFS);
  wire         w_rxd = wr & (paddr == cslp_pkg::RXD_OFS);
  wire         w_rrq = wr & (paddr == cslp_pkg::RRQ_OFS);
  wire         w_transmit_pending_register = wr & (paddr == cslp_pkg::TRANSMIT_PENDING_REGISTER_OFS);
  wire         w_transmit_cancel_register = wr & (paddr == cslp_pkg::TRANSMIT_CANCEL_REGISTER_OFS);
  wire         w_abak = wr & (paddr == cslp_pkg::ABAK_OFS);
  wire         w_txak = wr & (paddr == cslp_pkg::TXAK_OFS);
  wire  [15:0] general_status_register = {10'h000, bus_off, ~(in_run | in_resync), in_sleep, 1'b0,
                      twarn | rwarn, 1'b0};
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      cslp_pkg::MCR_OFS:  rd_mux = {16'h0000, mcr_reg};
      cslp_pkg::GSR_OFS:  rd_mux = {16'h0000, general_status_register};
      cslp_pkg::IFR_OFS:  rd_mux = {16'h0000, ifr_q};
      cslp_pkg::IMR_OFS:  rd_mux = {16'h0000, imr_reg};
      cslp_pkg::MBIM_OFS: rd_mux = mbim_reg;
      cslp_pkg::RXD_OFS:  rd_mux = rxd_q;
      cslp_pkg::RRQ_OFS:  rd_mux = rrq_q;
      cslp_pkg::TRANSMIT_PENDING_REGISTER_OFS: rd_mux = transmit_pending_register_reg;
      cslp_pkg::TRANSMIT_CANCEL_REGISTER_OFS: rd_mux = transmit_cancel_register_reg;
      cslp_pkg::ABAK_OFS: rd_mux = abak_q;
      cslp_pkg::TXAK_OFS: rd_mux = txak_q;
      cslp_pkg::ERRC_OFS: rd_mux = {16'h0000, tec_in[7:0], rec_reg[7:0]};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end
  assign pready = ce;
  assign pslverr = psel & penable & (~known | ~strb_ok);
  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine
  always_comb begin
    case (state_reg)
      cslp_pkg::ST_RUN: begin
        if (sleep_bit & bus_idle) begin
          state_next = cslp_pkg::ST_SLEEP;
        end else if (halt_bit & bus_idle) begin
          state_next = cslp_pkg::ST_HALT;
        end else begin
          state_next = cslp_pkg::ST_RUN;
        end
      end
      // Registers hold but for software writes and hardware flag and count events here
      cslp_pkg::ST_HALT: begin
        if (!halt_bit) begin
          state_next = sleep_bit ? cslp_pkg::ST_SLEEP : cslp_pkg::ST_RUN;
        end else begin
          state_next = cslp_pkg::ST_HALT;
        end
      end
      cslp_pkg::ST_SLEEP: begin
        if (!sleep_bit || wake_evt) begin
          state_next = cslp_pkg::ST_RESYNC;
        end else begin
          state_next = cslp_pkg::ST_SLEEP;
        end
      end
      cslp_pkg::ST_RESYNC: begin
        state_next = run11 ? cslp_pkg::ST_RUN : cslp_pkg::ST_RESYNC;
      end
      default: state_next = cslp_pkg::ST_RUN;
    endcase
  end
  assign bus_enable = in_run;
  assign low_power = in_sleep;
  assign store_enable = ~discard_reg;
  assign xfer_start = xfer_start_reg;
  assign tx_pending = transmit_pending_register_reg;
  assign tx_cancel = transmit_cancel_register_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Recessive run counter, shared by resync and bus-off recovery
  wire       counting = in_resync | bus_off;
  wire [3:0] rcnt_next = (!counting || (bit_tick && (!rx_s || run11))) ? 4'h0 :
                         (bit_tick ? rcnt_reg + 4'h1 : rcnt_reg);
  wire [8:0] rec_next = (bus_off & run11) ? rec_reg + 9'h001 :
                        boff_q & ~bus_off ? 9'h000 :
                        (rec_up & ~bus_off) ? rec_reg + 9'h001 :
                        (rec_down & ~bus_off & (rec_reg != 9'h000)) ? rec_reg - 9'h001 :
                        rec_reg;
  wire       rec96 = bus_off & run11 & (rec_next == cslp_pkg::WARN_LIMIT);
  wire       rec128 = bus_off & run11 & (rec_next == cslp_pkg::PASSIVE_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  wire [15:0] mcr_next = w_mcr ? (mcr_reg & ~lane[15:0]) | wdat[15:0] : mcr_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cslp_pkg::ST_RUN;
      mcr_reg <= cslp_pkg::MCR_RST;
      imr_reg <= cslp_pkg::IMR_RST;
      mbim_reg <= cslp_pkg::MBIM_RST;
      transmit_pending_register_reg <= 32'h0000_0000;
      transmit_cancel_register_reg <= 32'h0000_0000;
      rec_reg <= 9'h000;
      rcnt_reg <= 4'h0;
      discard_reg <= 1'b0;
      xfer_start_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      {twarn_q, rwarn_q, pass_q, boff_q, sw_stby_q} <= 5'b00000;
    end else if (ce) begin
      sw_stby_q <= sw_standby;
      if (init) begin
        state_reg <= cslp_pkg::ST_RUN;
        mcr_reg <= cslp_pkg::MCR_RST;
        imr_reg <= cslp_pkg::IMR_RST;
        mbim_reg <= cslp_pkg::MBIM_RST;
        transmit_pending_register_reg <= 32'h0000_0000;
        transmit_cancel_register_reg <= 32'h0000_0000;
        rec_reg <= 9'h000;
        rcnt_reg <= 4'h0;
        discard_reg <= 1'b0;
        xfer_start_reg <= 1'b0;
      end else begin
        state_reg <= state_next;
        // Wake by bus clears the request so software sees the awake state
        mcr_reg <= wake_evt ? mcr_next & ~(16'h0001 << cslp_pkg::MCR_SLEEP) : mcr_next;
        imr_reg <= w_imr ? (imr_reg & ~lane[15:0]) | wdat[15:0] : imr_reg;
        mbim_reg <= w_mbim ? (mbim_reg & ~lane) | wdat : mbim_reg;
        // Completion and cancel clear pending; late cancel also clears cancel
        transmit_pending_register_reg <= (transmit_pending_register_reg | (w_transmit_pending_register ? wdat : 32'h0000_0000))
                    & ~({32{tx_done}} & tx_oh) & ~({32{cancel_done}} & cn_oh);
        transmit_cancel_register_reg <= ((transmit_cancel_register_reg | (w_transmit_cancel_register ? wdat : 32'h0000_0000)) & transmit_pending_register_reg)
                    & ~({32{tx_done}} & tx_oh) & ~({32{cancel_done}} & cn_oh);
        rec_reg <= rec_next;
        rcnt_reg <= rcnt_next;
        discard_reg <= wake_evt ? 1'b1 : (rx_done ? 1'b0 : discard_reg);
        xfer_start_reg <= rx_dtc;
      end
      prdata_reg <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_reg;
      twarn_q <= twarn;
      rwarn_q <= rwarn;
      pass_q <= pass;
      boff_q <= bus_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag banks
  wire data_ok = rx_take & ~rx_remote & ~mbim_reg[rx_mbox] & ~rx_dtc;
  wire rmt_ok = rx_take & rx_remote & ~mbim_reg[rx_mbox] & ~rx_dtc;
  wire empty_ok = (tx_done & ~mbim_reg[tx_mbox]) | (cancel_done & ~mbim_reg[cancel_mbox]);
  always_comb begin
    ifr_set = 16'h0000;
    ifr_set[cslp_pkg::F_RST] = sw_stby_q & ~sw_standby;
    ifr_set[cslp_pkg::F_DATA] = data_ok;
    ifr_set[cslp_pkg::F_RMT] = rmt_ok;
    ifr_set[cslp_pkg::F_TXW] = twarn & ~twarn_q;
    ifr_set[cslp_pkg::F_RXW] = (rwarn & ~rwarn_q & ~bus_off) | rec96;
    ifr_set[cslp_pkg::F_PASS] = pass & ~pass_q;
    ifr_set[cslp_pkg::F_BOFF] = bus_off ^ boff_q;
    ifr_set[cslp_pkg::F_OVLD] = overload_sent | rec128;
    ifr_set[cslp_pkg::F_EMPTY] = empty_ok;
    ifr_set[cslp_pkg::F_OVWR] = overwrite_evt;
    ifr_set[cslp_pkg::F_ACT] = bus_act;
    ifr_set[cslp_pkg::F_TOVF] = timer_ovf;
    ifr_set[cslp_pkg::F_CMP0] = cmp0_match;
    ifr_set[cslp_pkg::F_CMP1] = cmp1_match;
  end
  assign ifr_clr = w_ifr ? wdat[15:0] : 16'h0000;
  assign rxd_set = rx_take ? rx_oh : 32'h0000_0000;
  assign rrq_set = (rx_take & rx_remote) ? rx_oh : 32'h0000_0000;
  assign rxd_clr = (w_rxd ? wdat : 32'h0000_0000) | {31'h0, xfer_done};
  assign rrq_clr = (w_rrq ? wdat : 32'h0000_0000) | {31'h0, xfer_done};
  assign abak_set = ({32{cancel_done}} & cn_oh) | ({32{tx_done}} & tx_oh & transmit_cancel_register_reg);
  assign txak_set = {32{tx_done}} & tx_oh;
  assign abak_clr = w_abak ? wdat : 32'h0000_0000;
  assign txak_clr = w_txak ? wdat : 32'h0000_0000;

  cslp_flags #(.W(16), .RST_VAL(cslp_pkg::IFR_RST)) u_ifr (
    .pclk(pclk), .presetn(presetn), .ce(ce), .load(init),
    .set(ifr_set), .clr(ifr_clr), .q(ifr_q));
  cslp_flags #(.W(32)) u_rxd (
    .pclk(pclk), .presetn(presetn), .ce(ce), .load(init),
    .set(rxd_set), .clr(rxd_clr), .q(rxd_q));
  cslp_flags #(.W(32)) u_rrq (
    .pclk(pclk), .presetn(presetn), .ce(ce), .load(init),
    .set(rrq_set), .clr(rrq_clr), .q(rrq_q));
  cslp_flags #(.W(32)) u_abak (
    .pclk(pclk), .presetn(presetn), .ce(ce), .load(init),
    .set(abak_set), .clr(abak_clr), .q(abak_q));
  cslp_flags #(.W(32)) u_txak (
    .pclk(pclk), .presetn(presetn), .ce(ce), .load(init),
    .set(txak_set), .clr(txak_clr), .q(txak_q));
  cslp_sync #(.RST_VAL(1'b1)) u_rx_sync (
    .pclk(pclk), .presetn(presetn), .ce(ce), .d(can_rx), .q(rx_s));

  ////////////////////////////////////////////////////////////////////////////
  // Request lines; reset event bypasses the mask, no line here starts a transfer
  wire [15:0] live = ifr_q & ~imr_reg;
  assign error_request_line = |live[cslp_pkg::F_BOFF:cslp_pkg::F_TXW];
  assign overrun_request_line = ifr_q[cslp_pkg::F_RST] | live[cslp_pkg::F_OVLD] |
                                live[cslp_pkg::F_OVWR] | |live[15:12];
  assign receive_request_line = live[cslp_pkg::F_DATA] | live[cslp_pkg::F_RMT];
  assign empty_request_line = live[cslp_pkg::F_EMPTY];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_sleep_defer: assert property (in_run & sleep_bit & ~bus_idle & ~init |=> !in_sleep)
    else $error("sleep entered on busy bus");
  chk_sleep_entry: assert property (in_run & sleep_bit & bus_idle & ce & ~init |=> in_sleep)
    else $error("sleep not entered");
  chk_halt_defer: assert property (in_run & halt_bit & ~bus_idle & ~init |=> !in_halt)
    else $error("halt entered on busy bus");
  chk_halt_exit: assert property (in_halt & ~halt_bit & ~sleep_bit & ce & ~init |=> in_run)
    else $error("halt not left");
  chk_resync_hold: assert property (in_sleep & ~sleep_bit & ce & ~init |=> ##[0:2] !bus_enable)
    else $error("bus used before resync");
  chk_wake_act: assert property (wake_evt & ce & ~init |=> in_resync & ifr_q[cslp_pkg::F_ACT] & ~store_enable)
    else $error("bus wake mishandled");
  chk_reset_stat: assert property (in_sleep |-> general_status_register[cslp_pkg::GSR_RST] & general_status_register[cslp_pkg::GSR_DISC])
    else $error("sleep status wrong");
  chk_xfer_clear: assert property (xfer_done & ~rx_take & ce |=> !rxd_q[0] & !rrq_q[0])
    else $error("mailbox 0 flags kept");
  chk_empty_mask: assert property (tx_done & ~cancel_done & mbim_reg[tx_mbox] & ~ifr_q[cslp_pkg::F_EMPTY]
                                   & ce & ~init |=> !ifr_q[cslp_pkg::F_EMPTY])
    else $error("masked mailbox set empty flag");
  chk_late_cancel: assert property (tx_done & transmit_cancel_register_reg[tx_mbox] & ce & ~init |=>
                                    abak_q[$past(tx_mbox)] & txak_q[$past(tx_mbox)] & !transmit_pending_register_reg[$past(tx_mbox)])
    else $error("late cancel not acknowledged");
  chk_boff_count: assert property (bus_off & run11 & ce & ~init & ~rec_up |=> rec_reg == $past(rec_reg) + 9'h001)
    else $error("bus-off count missed");
  cov_sleep_wake: cover property (in_sleep ##1 in_resync ##[1:200] in_run);
  cov_halt_sleep: cover property (in_halt ##1 in_sleep);
  cov_late_cancel: cover property (tx_done & transmit_cancel_register_reg[tx_mbox]);
endmodule // cslp_ctrl
`default_nettype wire

// >>> cslp_bus_model.sv
/* Far-side model: bus pin, bit ticks and idle level.
   Assumes pclk domain; bus recessive outside frames. */
`timescale 1ns/100ps
`default_nettype none
module cslp_bus_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic wake_req,
  input  wire logic traffic,
  output var  logic can_rx,
  output var  logic bit_tick,
  output var  logic bus_idle
);
  logic [3:0] dom_cnt;
  logic [1:0] tick_cnt;
  assign bus_idle = ~traffic;
  // Dominant burst long enough to pass the synchroniser
  assign can_rx = (dom_cnt == 4'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dom_cnt  <= 4'h0;
      tick_cnt <= 2'h0;
      bit_tick <= 1'b0;
    end else begin
      tick_cnt <= tick_cnt + 2'h1;
      bit_tick <= (tick_cnt == 2'h3);
      if (wake_req) begin
        dom_cnt <= 4'h8;
      end else if (dom_cnt != 4'h0) begin
        dom_cnt <= dom_cnt - 4'h1;
      end
    end
  end
endmodule // cslp_bus_model
`default_nettype wire

// >>> cslp_ctrl_bench.sv
/* Bench for mode control and flag grouping.
   Assumes zero-wait APB and the bus model above. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin #1; checked++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module cslp_ctrl_bench;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic rx_done = 0, rx_remote = 0, tx_done = 0, cancel_done = 0;
  // Timer events stay idle: no test drives the timer overflow or compare inputs
  logic overload_sent = 0, overwrite_evt = 0, timer_ovf = 0, cmp0_match = 0;
  logic cmp1_match = 0, rec_up = 0, rec_down = 0, hw_standby = 0, sw_standby = 0;
  logic xfer_done = 0, wake_req = 0, traffic = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [3:0] pstrb = 0;
  logic [4:0] rx_mbox = 0, tx_mbox = 0, cancel_mbox = 0;
  logic [8:0] tec_in = 0;
  wire logic can_rx, bit_tick, bus_idle, pready, pslverr, xfer_start, bus_enable;
  wire logic store_enable, low_power, error_request_line, overrun_request_line;
  wire logic receive_request_line, empty_request_line;
  wire logic [31:0] prdata, tx_pending, tx_cancel;
  int checked = 0, miscompares = 0, cycles = 0;
  always #5 pclk = ~pclk;
  cslp_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .can_rx(can_rx), .bit_tick(bit_tick),
    .bus_idle(bus_idle), .rx_done(rx_done), .rx_mbox(rx_mbox), .rx_remote(rx_remote),
    .tx_done(tx_done), .tx_mbox(tx_mbox), .cancel_done(cancel_done),
    .cancel_mbox(cancel_mbox), .overload_sent(overload_sent), .overwrite_evt(overwrite_evt),
    .timer_ovf(timer_ovf), .cmp0_match(cmp0_match), .cmp1_match(cmp1_match),
    .tec_in(tec_in), .rec_up(rec_up), .rec_down(rec_down), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .xfer_done(xfer_done), .xfer_start(xfer_start),
    .bus_enable(bus_enable), .store_enable(store_enable), .low_power(low_power),
    .tx_pending(tx_pending), .tx_cancel(tx_cancel),
    .error_request_line(error_request_line), .overrun_request_line(overrun_request_line),
    .receive_request_line(receive_request_line), .empty_request_line(empty_request_line));
  cslp_bus_model far (.pclk(pclk), .presetn(presetn), .wake_req(wake_req),
    .traffic(traffic), .can_rx(can_rx), .bit_tick(bit_tick), .bus_idle(bus_idle));
  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= {2'b00, wr, wr};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, well above the run length
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(cslp_pkg::IFR_OFS, 32'h0000_0001);
    `CHK(overrun_request_line, 1'b1)
    rd(cslp_pkg::MBIM_OFS, 32'hFFFF_FFFF);
    apb(1'b1, cslp_pkg::IFR_OFS, 32'h0000_0001);
    rd(cslp_pkg::IFR_OFS, 32'h0000_0000);
    $display("test reset done");
    traffic <= 1'b1;
    apb(1'b1, cslp_pkg::MCR_OFS, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    rd(cslp_pkg::GSR_OFS, 32'h0000_0000);
    traffic <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(cslp_pkg::GSR_OFS, 32'h0000_0010);
    rd(cslp_pkg::IMR_OFS, 32'h0000_FFFF);
    apb(1'b1, cslp_pkg::MCR_OFS, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    rd(cslp_pkg::GSR_OFS, 32'h0000_0000);
    $display("test halt done");
    apb(1'b1, cslp_pkg::MCR_OFS, 32'h0000_0020);
    repeat (3) @(posedge pclk);
    rd(cslp_pkg::GSR_OFS, 32'h0000_0018);
    `CHK(low_power, 1'b1)
    apb(1'b1, cslp_pkg::MCR_OFS, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    `CHK({low_power, bus_enable}, 2'b00)
    repeat (60) @(posedge pclk);
    `CHK(bus_enable, 1'b1)
    $display("test sleep done");
    apb(1'b1, cslp_pkg::IMR_OFS, 32'h0000_EFFF);
    apb(1'b1, cslp_pkg::MCR_OFS, 32'h0000_0082);
    repeat (3) @(posedge pclk);
    rd(cslp_pkg::GSR_OFS, 32'h0000_0010);
    apb(1'b1, cslp_pkg::IFR_OFS, 32'h0000_FFFF);
    apb(1'b1, cslp_pkg::MCR_OFS, 32'h0000_00A0);
    repeat (3) @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(cslp_pkg::IFR_OFS, 32'h0000_1000);
    rd(cslp_pkg::MCR_OFS, 32'h0000_0080);
    `CHK({overrun_request_line, store_enable}, 2'b10)
    apb(1'b1, cslp_pkg::IMR_OFS, 32'h0000_FFFF);
    `CHK(overrun_request_line, 1'b0)
    $display("test wake done");
    apb(1'b1, cslp_pkg::TRANSMIT_PENDING_REGISTER_OFS, 32'h0000_0002);
    apb(1'b1, cslp_pkg::TRANSMIT_CANCEL_REGISTER_OFS, 32'h0000_0002);
    tx_mbox <= 5'h01;
    tx_done <= 1'b1;
    @(posedge pclk);
    tx_done <= 1'b0;
    rd(cslp_pkg::TRANSMIT_PENDING_REGISTER_OFS, 32'h0000_0000);
    rd(cslp_pkg::ABAK_OFS, 32'h0000_0002);
    rd(cslp_pkg::TXAK_OFS, 32'h0000_0002);
    `CHK({tx_pending, tx_cancel}, 64'h0)
    apb(1'b1, 8'h30, 32'h0000_0001);
    `CHK(er, 1'b1)
    $display("test cancel done");
    apb(1'b1, cslp_pkg::MCR_OFS, 32'h0000_0100);
    apb(1'b1, cslp_pkg::MBIM_OFS, 32'h0000_0000);
    apb(1'b1, cslp_pkg::IMR_OFS, 32'h0000_FFF1);
    @(posedge pclk);
    rx_done <= 1'b1;
    @(posedge pclk);
    rx_done <= 1'b0;
    `CHK({xfer_start, store_enable}, 2'b01)
    @(posedge pclk);
    rx_done <= 1'b1;
    @(posedge pclk);
    rx_done <= 1'b0;
    `CHK({xfer_start, receive_request_line}, 2'b10)
    rd(cslp_pkg::RXD_OFS, 32'h0000_0001);
    xfer_done <= 1'b1;
    @(posedge pclk);
    xfer_done <= 1'b0;
    rd(cslp_pkg::RXD_OFS, 32'h0000_0000);
    tec_in <= 9'h060;
    repeat (2) @(posedge pclk);
    `CHK(error_request_line, 1'b1)
    $display("test transfer done");
    summarize();
  end
endmodule // cslp_ctrl_bench
`default_nettype wire
